// File: lesc_counters.sv
/*
 * lesc_counters: saturating per-tributary data link counters and
 * link-wide station counters, with sticky cause flags, readable by
 * firmware over a plain register port.
 * assumes: events are one-cycle strobes from the frame logic on the
 * same clock; tributary index is stable beside its events.
 */
// Strobed register access and the register offsets are this design's own decisions.
//
// Overview of operation
// - count each reply request sent, 8-bit
// - count acks answering received reply requests
// - no buffer: flag, count, nak code eight
// - buffer short: flag, count, nak code 16
// - nak eight received: flag, remote buffer count
// - nak 16 received: flag, remote buffer count
// - selection timeouts only half duplex or control
// - quiet select expiry: no reply flag, count
// - busy select expiry: partial reply flag, count
// - carrier, sync, lead char mean attempt
// - count new data sent, 16-bit saturating
// - count good in-order data received, saturating
// - count select messages sent, restricted modes
// - station counters 8-bit, one shared set
// - station counters clear on reset or command
// - nak nine received: remote overrun, count
// - header format error: flag, count, nak 17
// - control station address mismatch: flag, count
// - babbling or streaming sets streaming flag
// - overrun: nak nine flag, else no-nak flag
// - underrun or nak 17 received: local count
// - global header and maintenance data checks
// - data link error counters stop at 255
// - tributary counters clear on three events
`timescale 1ns/1ps

module lesc_counters
  import lesc_pkg::*;
#(
  parameter int unsigned NUM_TRIB = 4,
  parameter int unsigned TRIB_W = 2
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // configuration
  input wire lesc_mode_e MODE_I,
  input wire logic RUN_STATE_I,
  input wire logic HDR_RX_ACTIVE_I,
  // tributary and station events
  input wire logic [TRIB_W-1:0] TRIB_SEL_I,
  input wire lesc_link_ev_s LINK_EV_I,
  input wire lesc_stn_ev_s STN_EV_I,
  // clear commands
  input wire logic TRIB_ESTABLISH_I,
  input wire logic TRIB_READ_CLEAR_I,
  input wire logic [TRIB_W-1:0] CLR_TRIB_I,
  input wire logic GLOBAL_READ_CLEAR_I,
  // nak request to the transmitter
  output logic NAK_TX_REQ_O,
  output logic [7:0] NAK_TX_REASON_O,
  // firmware read port
  input wire logic [TRIB_W+3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O
);

  // ****************************************
  // storage
  // ****************************************
  typedef struct packed {
    logic [7:0] lrep;
    logic [7:0] rrep;
    logic [7:0] lbuf;
    logic [7:0] rbuf;
    logic [7:0] selto;
    logic [15:0] txmsg;
    logic [15:0] rxmsg;
    logic [15:0] selint;
    lesc_dl_flags_s fl;
  } lesc_dl_s;

  lesc_dl_s dl_q [NUM_TRIB];
  lesc_dl_s dl_d [NUM_TRIB];
  logic [7:0] rstn_q, rstn_d, lstn_q, lstn_d, ghbc_q, ghbc_d, mdbc_q, mdbc_d;
  lesc_st_flags_s stf_q, stf_d;
  logic attempt_q, attempt_d;
  logic nak_q, nak_d;
  logic [7:0] reason_q, reason_d;
  logic [15:0] rdata_q, rdata_d;

  // saturating increments
  function automatic logic [7:0] inc8(input logic [7:0] v, input logic en);
    inc8 = (en && v != LESC_CNT8_MAX) ? v + 8'h01 : v;
  endfunction : inc8

  function automatic logic [15:0] inc16(input logic [15:0] v, input logic en);
    inc16 = (en && v != LESC_CNT16_MAX) ? v + 16'h0001 : v;
  endfunction : inc16

  // ****************************************
  // event decode
  // ****************************************
  logic sel_mode, nak8, nak9, nak16, nak17, attempt_now, sel_busy;
  logic ovr_nak;
  assign sel_mode = (MODE_I == LESC_MODE_HDX_P2P) || (MODE_I == LESC_MODE_MP_CTRL);
  assign nak8 = LINK_EV_I.nak_rx_valid && LINK_EV_I.nak_rx_reason == LESC_NAK_BUF_UNAVAIL;
  assign nak9 = LINK_EV_I.nak_rx_valid && LINK_EV_I.nak_rx_reason == LESC_NAK_OVERRUN;
  assign nak16 = LINK_EV_I.nak_rx_valid && LINK_EV_I.nak_rx_reason == LESC_NAK_BUF_SHORT;
  assign nak17 = LINK_EV_I.nak_rx_valid && LINK_EV_I.nak_rx_reason == LESC_NAK_HDR_FORMAT;
  // any of these marks the interval as answered in part
  assign attempt_now = LINK_EV_I.carrier_seen || LINK_EV_I.sync_seen
                       || LINK_EV_I.lead_char_seen || LINK_EV_I.valid_ctrl_rx
                       || LINK_EV_I.valid_hdr_rx;
  assign sel_busy = attempt_q || attempt_now;
  // no nak on a tributary header overrun, or outside run state in the other modes
  assign ovr_nak = (MODE_I == LESC_MODE_MP_TRIB) ? !HDR_RX_ACTIVE_I : RUN_STATE_I;

  // ****************************************
  // select interval tracker
  // ****************************************
  always_comb begin
    attempt_d = attempt_q;
    if (LINK_EV_I.sel_timer_expired || LINK_EV_I.tx_select_msg) begin
      attempt_d = 1'b0;
    end else if (attempt_now) begin
      attempt_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      attempt_q <= 1'b0;
    end else begin
      attempt_q <= attempt_d;
    end
  end

  // ****************************************
  // per-tributary data link counters
  // ****************************************
  // clear is applied first so a same-cycle event still counts
  for (genvar t = 0; t < NUM_TRIB; t++) begin : g_trib
    logic hit, clr;
    assign hit = TRIB_SEL_I == TRIB_W'(t);
    assign clr = (TRIB_ESTABLISH_I || TRIB_READ_CLEAR_I) && CLR_TRIB_I == TRIB_W'(t);

    always_comb begin
      dl_d[t] = dl_q[t];
      if (clr) begin
        dl_d[t] = '0;
      end
      if (hit) begin
        dl_d[t].lrep = inc8(dl_d[t].lrep, LINK_EV_I.rep_sent);
        dl_d[t].rrep = inc8(dl_d[t].rrep, LINK_EV_I.ack_for_rep);
        dl_d[t].lbuf = inc8(dl_d[t].lbuf,
                            LINK_EV_I.rx_no_buffer || LINK_EV_I.rx_buffer_short);
        dl_d[t].rbuf = inc8(dl_d[t].rbuf, nak8 || nak16);
        dl_d[t].txmsg = inc16(dl_d[t].txmsg, LINK_EV_I.data_tx_new);
        dl_d[t].rxmsg = inc16(dl_d[t].rxmsg, LINK_EV_I.data_rx_good);
        if (LINK_EV_I.rx_no_buffer) dl_d[t].fl.local_buffer_unavailable_flag = 1'b1;
        if (LINK_EV_I.rx_buffer_short) dl_d[t].fl.local_buffer_short_flag = 1'b1;
        if (nak8) dl_d[t].fl.remote_buffer_unavailable_flag = 1'b1;
        if (nak16) dl_d[t].fl.remote_buffer_short_flag = 1'b1;
        if (sel_mode) begin
          dl_d[t].selint = inc16(dl_d[t].selint, LINK_EV_I.tx_select_msg);
          dl_d[t].selto = inc8(dl_d[t].selto, LINK_EV_I.sel_timer_expired);
          if (LINK_EV_I.sel_timer_expired && !sel_busy) begin
            dl_d[t].fl.no_select_reply_flag = 1'b1;
          end
          if (LINK_EV_I.sel_timer_expired && sel_busy) begin
            dl_d[t].fl.partial_select_reply_flag = 1'b1;
          end
        end
      end
    end

    always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
        dl_q[t] <= '0;
      end else begin
        dl_q[t] <= dl_d[t];
      end
    end
  end

  // ****************************************
  // station counters, one set for the link
  // ****************************************
  always_comb begin
    rstn_d = rstn_q;
    lstn_d = lstn_q;
    ghbc_d = ghbc_q;
    mdbc_d = mdbc_q;
    stf_d = stf_q;
    if (GLOBAL_READ_CLEAR_I) begin
      rstn_d = LESC_CNT8_RST;
      lstn_d = LESC_CNT8_RST;
      ghbc_d = LESC_CNT8_RST;
      mdbc_d = LESC_CNT8_RST;
      stf_d = '0;
    end
    if (nak9) stf_d.remote_overrun_flag = 1'b1;
    if (STN_EV_I.hdr_format_err) stf_d.remote_header_format_flag = 1'b1;
    if (STN_EV_I.addr_mismatch && MODE_I == LESC_MODE_MP_CTRL) begin
      stf_d.remote_selection_address_flag = 1'b1;
    end
    if (STN_EV_I.babble || STN_EV_I.no_release) stf_d.remote_streaming_flag = 1'b1;
    if (STN_EV_I.rx_overrun && ovr_nak) stf_d.overrun_with_nak_flag = 1'b1;
    if (STN_EV_I.rx_overrun && !ovr_nak) stf_d.overrun_without_nak_flag = 1'b1;
    if (STN_EV_I.tx_underrun) stf_d.local_underrun_flag = 1'b1;
    if (nak17) stf_d.local_header_format_flag = 1'b1;
    rstn_d = inc8(rstn_d, nak9 || STN_EV_I.hdr_format_err || STN_EV_I.babble
                  || STN_EV_I.no_release
                  || (STN_EV_I.addr_mismatch && MODE_I == LESC_MODE_MP_CTRL));
    lstn_d = inc8(lstn_d, STN_EV_I.rx_overrun || STN_EV_I.tx_underrun || nak17);
    ghbc_d = inc8(ghbc_d, STN_EV_I.hdr_bcc_global);
    mdbc_d = inc8(mdbc_d, STN_EV_I.maint_data_bcc);
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rstn_q <= LESC_CNT8_RST;
      lstn_q <= LESC_CNT8_RST;
      ghbc_q <= LESC_CNT8_RST;
      mdbc_q <= LESC_CNT8_RST;
      stf_q <= '0;
    end else begin
      rstn_q <= rstn_d;
      lstn_q <= lstn_d;
      ghbc_q <= ghbc_d;
      mdbc_q <= mdbc_d;
      stf_q <= stf_d;
    end
  end

  // ****************************************
  // nak request, priority header error over overrun over buffer
  // ****************************************
  always_comb begin
    nak_d = 1'b1;
    reason_d = reason_q;
    if (STN_EV_I.hdr_format_err) begin
      reason_d = LESC_NAK_HDR_FORMAT;
    end else if (STN_EV_I.rx_overrun && ovr_nak) begin
      reason_d = LESC_NAK_OVERRUN;
    end else if (LINK_EV_I.rx_buffer_short) begin
      reason_d = LESC_NAK_BUF_SHORT;
    end else if (LINK_EV_I.rx_no_buffer) begin
      reason_d = LESC_NAK_BUF_UNAVAIL;
    end else begin
      nak_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      nak_q <= 1'b0;
      reason_q <= LESC_NAK_NONE;
    end else begin
      nak_q <= nak_d;
      reason_q <= reason_d;
    end
  end

  assign NAK_TX_REQ_O = nak_q;
  assign NAK_TX_REASON_O = reason_q;

  // ****************************************
  // firmware read port; counters are read-only, writes ignored
  // ****************************************
  logic [TRIB_W-1:0] rd_trib;
  logic [3:0] rd_idx;
  assign rd_trib = ADDR_I[TRIB_W+3:4];
  assign rd_idx = ADDR_I[3:0];

  always_comb begin
    rdata_d = 16'h0000;
    if (RD_I) begin
      unique case (rd_idx)
        LESC_IDX_LREP: rdata_d = {8'h00, dl_q[rd_trib].lrep};
        LESC_IDX_RREP: rdata_d = {8'h00, dl_q[rd_trib].rrep};
        LESC_IDX_LBUF: rdata_d = {8'h00, dl_q[rd_trib].lbuf};
        LESC_IDX_RBUF: rdata_d = {8'h00, dl_q[rd_trib].rbuf};
        LESC_IDX_SELTO: rdata_d = {8'h00, dl_q[rd_trib].selto};
        LESC_IDX_TXMSG: rdata_d = dl_q[rd_trib].txmsg;
        LESC_IDX_RXMSG: rdata_d = dl_q[rd_trib].rxmsg;
        LESC_IDX_SELINT: rdata_d = dl_q[rd_trib].selint;
        LESC_IDX_DLFLAG: rdata_d = {10'h000, dl_q[rd_trib].fl};
        LESC_IDX_RSTN: rdata_d = {8'h00, rstn_q};
        LESC_IDX_LSTN: rdata_d = {8'h00, lstn_q};
        LESC_IDX_GHBC: rdata_d = {8'h00, ghbc_q};
        LESC_IDX_MDBC: rdata_d = {8'h00, mdbc_q};
        LESC_IDX_STFLAG: rdata_d = {8'h00, stf_q};
        default: rdata_d = 16'h0000; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  property p_rep_count;
    @(posedge CLOCK_I) disable iff (RST_I)
    (LINK_EV_I.rep_sent && TRIB_SEL_I == TRIB_W'(1) && !TRIB_ESTABLISH_I && !TRIB_READ_CLEAR_I
     && dl_q[1].lrep != LESC_CNT8_MAX) |=> dl_q[1].lrep == $past(dl_q[1].lrep) + 8'h01;
  endproperty
  a_rep_count: assert property (p_rep_count) else $error("reply count missed");

  property p_sat8;
    @(posedge CLOCK_I) disable iff (RST_I)
    (dl_q[3].lrep == LESC_CNT8_MAX && !TRIB_ESTABLISH_I && !TRIB_READ_CLEAR_I)
      |=> dl_q[3].lrep == LESC_CNT8_MAX;
  endproperty
  a_sat8: assert property (p_sat8) else $error("error counter wrapped");

  property p_nak8_out;
    @(posedge CLOCK_I) disable iff (RST_I)
    (LINK_EV_I.rx_no_buffer && !LINK_EV_I.rx_buffer_short && !STN_EV_I.hdr_format_err
     && !STN_EV_I.rx_overrun) |=> NAK_TX_REQ_O && NAK_TX_REASON_O == LESC_NAK_BUF_UNAVAIL;
  endproperty
  a_nak8_out: assert property (p_nak8_out) else $error("no nak eight sent");

  property p_nak17_out;
    @(posedge CLOCK_I) disable iff (RST_I)
    STN_EV_I.hdr_format_err |=> NAK_TX_REQ_O && NAK_TX_REASON_O == LESC_NAK_HDR_FORMAT
                                && stf_q.remote_header_format_flag;
  endproperty
  a_nak17_out: assert property (p_nak17_out) else $error("header error not handled");

  property p_selto_mode;
    @(posedge CLOCK_I) disable iff (RST_I)
    (!sel_mode && !TRIB_ESTABLISH_I && !TRIB_READ_CLEAR_I) |=> $stable(dl_q[1].selto);
  endproperty
  a_selto_mode: assert property (p_selto_mode) else $error("selection count in wrong mode");

  property p_gclear;
    @(posedge CLOCK_I) disable iff (RST_I)
    (GLOBAL_READ_CLEAR_I && !STN_EV_I.hdr_bcc_global) |=> ghbc_q == LESC_CNT8_RST;
  endproperty
  a_gclear: assert property (p_gclear) else $error("station counter not cleared");

  property p_sticky;
    @(posedge CLOCK_I) disable iff (RST_I)
    (stf_q.local_underrun_flag && !GLOBAL_READ_CLEAR_I) |=> stf_q.local_underrun_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped early");

  property p_ovr_split;
    @(posedge CLOCK_I) disable iff (RST_I)
    (STN_EV_I.rx_overrun && !ovr_nak)
      |=> stf_q.overrun_without_nak_flag && lstn_q != LESC_CNT8_RST;
  endproperty
  a_ovr_split: assert property (p_ovr_split) else $error("overrun without nak missed");

  property p_read_lat;
    @(posedge CLOCK_I) disable iff (RST_I)
    (RD_I && ADDR_I[3:0] == LESC_IDX_LSTN) |=> RDATA_O == {8'h00, $past(lstn_q)};
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data wrong");

endmodule : lesc_counters

// File: lesc_pkg.sv
/*
 * lesc_pkg: shared constants and carriers for the link error and
 * statistics counter block.
 * assumes: one clock domain; event strobes arrive from same-clock logic.
 */
package lesc_pkg;

  // ****************************************
  // widths and limits
  // ****************************************
  localparam int unsigned LESC_CNT8_W = 8;
  localparam int unsigned LESC_CNT16_W = 16;
  localparam logic [7:0] LESC_CNT8_MAX = 8'hff;
  localparam logic [15:0] LESC_CNT16_MAX = 16'hffff;
  localparam logic [7:0] LESC_CNT8_RST = 8'h00;
  localparam logic [15:0] LESC_CNT16_RST = 16'h0000;

  // ****************************************
  // reason codes carried in a negative acknowledge
  // ****************************************
  localparam logic [7:0] LESC_NAK_BUF_UNAVAIL = 8'h08;
  localparam logic [7:0] LESC_NAK_OVERRUN = 8'h09;
  localparam logic [7:0] LESC_NAK_BUF_SHORT = 8'h10;
  localparam logic [7:0] LESC_NAK_HDR_FORMAT = 8'h11;
  localparam logic [7:0] LESC_NAK_NONE = 8'h00;

  // ****************************************
  // counter map inside the firmware read window
  // ****************************************
  localparam logic [3:0] LESC_IDX_LREP = 4'h0;
  localparam logic [3:0] LESC_IDX_RREP = 4'h1;
  localparam logic [3:0] LESC_IDX_LBUF = 4'h2;
  localparam logic [3:0] LESC_IDX_RBUF = 4'h3;
  localparam logic [3:0] LESC_IDX_SELTO = 4'h4;
  localparam logic [3:0] LESC_IDX_TXMSG = 4'h5;
  localparam logic [3:0] LESC_IDX_RXMSG = 4'h6;
  localparam logic [3:0] LESC_IDX_SELINT = 4'h7;
  localparam logic [3:0] LESC_IDX_DLFLAG = 4'h8;
  localparam logic [3:0] LESC_IDX_RSTN = 4'h9;
  localparam logic [3:0] LESC_IDX_LSTN = 4'ha;
  localparam logic [3:0] LESC_IDX_GHBC = 4'hb;
  localparam logic [3:0] LESC_IDX_MDBC = 4'hc;
  localparam logic [3:0] LESC_IDX_STFLAG = 4'hd;

  // ****************************************
  // station operating modes
  // ****************************************
  typedef enum logic [1:0] {
    LESC_MODE_FDX_P2P,
    LESC_MODE_HDX_P2P,
    LESC_MODE_MP_CTRL,
    LESC_MODE_MP_TRIB
  } lesc_mode_e;

  // ****************************************
  // event carriers
  // ****************************************
  // per-tributary events, each a one-cycle strobe
  typedef struct packed {
    logic rep_sent;
    logic ack_for_rep;
    logic rx_no_buffer;
    logic rx_buffer_short;
    logic nak_rx_valid;
    logic [7:0] nak_rx_reason;
    logic data_tx_new;
    logic data_rx_good;
    logic tx_select_msg;
    logic sel_timer_expired;
    logic valid_ctrl_rx;
    logic valid_hdr_rx;
    logic carrier_seen;
    logic sync_seen;
    logic lead_char_seen;
  } lesc_link_ev_s;

  // link-wide events, each a one-cycle strobe
  typedef struct packed {
    logic hdr_format_err;
    logic addr_mismatch;
    logic babble;
    logic no_release;
    logic rx_overrun;
    logic tx_underrun;
    logic hdr_bcc_global;
    logic maint_data_bcc;
  } lesc_stn_ev_s;

  // cause flags of the data link counters
  typedef struct packed {
    logic local_buffer_unavailable_flag;
    logic local_buffer_short_flag;
    logic remote_buffer_unavailable_flag;
    logic remote_buffer_short_flag;
    logic no_select_reply_flag;
    logic partial_select_reply_flag;
  } lesc_dl_flags_s;

  // cause flags of the station counters
  typedef struct packed {
    logic remote_overrun_flag;
    logic remote_header_format_flag;
    logic remote_selection_address_flag;
    logic remote_streaming_flag;
    logic overrun_with_nak_flag;
    logic overrun_without_nak_flag;
    logic local_underrun_flag;
    logic local_header_format_flag;
  } lesc_st_flags_s;

endpackage : lesc_pkg

// File: lesc_remote_model.sv
/*
 * lesc_remote_model: stand-in for the far-side frame logic; it turns
 * bench commands into link and station event strobes one cycle later.
 * assumes: same clock as the counters; commands change after an edge.
 */
`timescale 1ns/1ps

module lesc_remote_model
  import lesc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commands from the bench
  input wire logic [21:0] link_cmd_i,
  input wire logic [7:0] stn_cmd_i,
  // event strobes toward the counters
  output lesc_link_ev_s link_ev_o,
  output lesc_stn_ev_s stn_ev_o
);
  lesc_link_ev_s link_d;
  lesc_link_ev_s link_q;
  lesc_stn_ev_s stn_d;
  lesc_stn_ev_s stn_q;

  // ****************************************
  // event launch
  // ****************************************
  // quiet during reset, so nothing counts at the release edge
  always_comb begin
    link_d = rst_i ? '0 : lesc_link_ev_s'(link_cmd_i);
    stn_d = rst_i ? '0 : lesc_stn_ev_s'(stn_cmd_i);
  end

  // strobes leave on the edge, like the real frame logic
  always_ff @(posedge clk_i) begin
    link_q <= link_d;
    stn_q <= stn_d;
  end

  assign link_ev_o = link_q;
  assign stn_ev_o = stn_q;
endmodule : lesc_remote_model

// File: link_error_statistics_counters_tb.sv
/*
 * link_error_statistics_counters_tb: self-checking bench for the
 * counter block; a table of single events, then hand-written cases.
 * assumes: lesc_pkg and lesc_remote_model compiled before this file.
 */
`timescale 1ns/1ps

module link_error_statistics_counters_tb
  import lesc_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic CLOCK_I, RST_I, RUN_STATE_I, HDR_RX_ACTIVE_I, NAK_TX_REQ_O;
  logic TRIB_ESTABLISH_I, TRIB_READ_CLEAR_I, GLOBAL_READ_CLEAR_I, WR_I, RD_I;
  lesc_mode_e MODE_I;
  logic [1:0] TRIB_SEL_I, CLR_TRIB_I;
  lesc_link_ev_s LINK_EV_I;
  lesc_stn_ev_s STN_EV_I;
  logic [5:0] ADDR_I;
  logic [7:0] NAK_TX_REASON_O, stn_cmd;
  logic [15:0] WDATA_I, RDATA_O;
  logic [21:0] link_cmd;
  int n_fail, samples_checked;
  typedef struct packed {
    logic [21:0] lev;
    logic [7:0] sev;
    logic [3:0] idx;
    logic [15:0] exp;
    logic [7:0] nak;
  } lesc_row_s;
  lesc_row_s rows[$];

  lesc_counters #(.NUM_TRIB(4), .TRIB_W(2)) u_dut (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .MODE_I(MODE_I), .RUN_STATE_I(RUN_STATE_I),
    .HDR_RX_ACTIVE_I(HDR_RX_ACTIVE_I), .TRIB_SEL_I(TRIB_SEL_I), .LINK_EV_I(LINK_EV_I),
    .STN_EV_I(STN_EV_I), .TRIB_ESTABLISH_I(TRIB_ESTABLISH_I),
    .TRIB_READ_CLEAR_I(TRIB_READ_CLEAR_I), .CLR_TRIB_I(CLR_TRIB_I),
    .GLOBAL_READ_CLEAR_I(GLOBAL_READ_CLEAR_I), .NAK_TX_REQ_O(NAK_TX_REQ_O),
    .NAK_TX_REASON_O(NAK_TX_REASON_O), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O));

  lesc_remote_model u_far (.clk_i(CLOCK_I), .rst_i(RST_I), .link_cmd_i(link_cmd),
    .stn_cmd_i(stn_cmd), .link_ev_o(LINK_EV_I), .stn_ev_o(STN_EV_I));

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one read cycle; data stands only in the cycle after the strobe
  task automatic rdchk(input logic [1:0] t, input logic [3:0] idx, input logic [15:0] exp);
    @(posedge CLOCK_I);
    RD_I <= 1'b1;
    ADDR_I <= {t, idx};
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    #1 chk(RDATA_O, exp);
  endtask : rdchk

  // hold a command n cycles; returns just after the edge that takes the last strobe
  task automatic fire(input logic [21:0] lev, input logic [7:0] sev, input int n);
    @(posedge CLOCK_I);
    link_cmd <= lev;
    stn_cmd <= sev;
    repeat (n) @(posedge CLOCK_I);
    link_cmd <= '0;
    stn_cmd <= '0;
    @(posedge CLOCK_I);
    #1;
  endtask : fire

  // bits: reset, establish, tributary read-clear, global read-clear
  task automatic ctl(input logic [3:0] m, input logic [1:0] t);
    @(posedge CLOCK_I);
    {RST_I, TRIB_ESTABLISH_I, TRIB_READ_CLEAR_I, GLOBAL_READ_CLEAR_I} <= m;
    CLR_TRIB_I <= t;
    @(posedge CLOCK_I);
    {RST_I, TRIB_ESTABLISH_I, TRIB_READ_CLEAR_I, GLOBAL_READ_CLEAR_I} <= 4'h0;
  endtask : ctl

  function automatic logic [21:0] lk(input int b, input logic [7:0] r);
    lk = 22'h0;
    if (b >= 0) lk[b] = 1'b1;
    lk[16:9] = r;
  endfunction : lk

  task automatic add(input int lb, input logic [7:0] r, input int sb, input logic [3:0] idx,
                     input logic [15:0] exp, input logic [7:0] nak);
    logic [7:0] s;
    s = 8'h00;
    if (sb >= 0) s[sb] = 1'b1;
    rows.push_back('{lk(lb, r), s, idx, exp, nak});
  endtask : add

  // overrun under one configuration; only some configurations send a nak
  task automatic ovr(input lesc_mode_e m, input logic run, input logic hdr, input logic req);
    MODE_I <= m;
    RUN_STATE_I <= run;
    HDR_RX_ACTIVE_I <= hdr;
    fire(22'h0, 8'h08, 1);
    chk({15'h0000, NAK_TX_REQ_O}, {15'h0000, req});
  endtask : ovr

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    CLOCK_I = 1'b0;
    forever #4 CLOCK_I = ~CLOCK_I;
  end

  // a hang counts as a failure and ends the run
  initial begin
    repeat (100000) @(posedge CLOCK_I);
    n_fail++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {RST_I, TRIB_ESTABLISH_I, TRIB_READ_CLEAR_I, GLOBAL_READ_CLEAR_I} = 4'h8;
    {WR_I, RD_I, RUN_STATE_I, HDR_RX_ACTIVE_I} = 4'h2;
    MODE_I = LESC_MODE_HDX_P2P;
    {TRIB_SEL_I, CLR_TRIB_I, ADDR_I, WDATA_I} = '0;
    {link_cmd, stn_cmd, n_fail, samples_checked} = '0;
    add(21, 8'h00, -1, LESC_IDX_LREP, 16'h0001, 8'h00);
    add(20, 8'h00, -1, LESC_IDX_RREP, 16'h0001, 8'h00);
    add(19, 8'h00, -1, LESC_IDX_LBUF, 16'h0001, 8'h08);
    add(18, 8'h00, -1, LESC_IDX_LBUF, 16'h0002, 8'h10);
    add(17, 8'h08, -1, LESC_IDX_RBUF, 16'h0001, 8'h00);
    add(17, 8'h10, -1, LESC_IDX_RBUF, 16'h0002, 8'h00);
    add(8, 8'h00, -1, LESC_IDX_TXMSG, 16'h0001, 8'h00);
    add(7, 8'h00, -1, LESC_IDX_RXMSG, 16'h0001, 8'h00);
    add(6, 8'h00, -1, LESC_IDX_SELINT, 16'h0001, 8'h00);
    add(5, 8'h00, -1, LESC_IDX_SELTO, 16'h0001, 8'h00);
    for (int b = 0; b < 5; b++) begin
      add(b, 8'h00, -1, LESC_IDX_SELTO, 16'(b + 1), 8'h00);
      add(5, 8'h00, -1, LESC_IDX_SELTO, 16'(b + 2), 8'h00);
    end
    add(-1, 8'h00, -1, LESC_IDX_DLFLAG, 16'h003f, 8'h00);
    add(17, 8'h09, -1, LESC_IDX_RSTN, 16'h0001, 8'h00);
    add(-1, 8'h00, 7, LESC_IDX_RSTN, 16'h0002, 8'h11);
    add(-1, 8'h00, 5, LESC_IDX_RSTN, 16'h0003, 8'h00);
    add(-1, 8'h00, 4, LESC_IDX_RSTN, 16'h0004, 8'h00);
    add(-1, 8'h00, 6, LESC_IDX_RSTN, 16'h0004, 8'h00);
    add(-1, 8'h00, 2, LESC_IDX_LSTN, 16'h0001, 8'h00);
    add(17, 8'h11, -1, LESC_IDX_LSTN, 16'h0002, 8'h00);
    add(-1, 8'h00, 3, LESC_IDX_LSTN, 16'h0003, 8'h09);
    add(-1, 8'h00, 1, LESC_IDX_GHBC, 16'h0001, 8'h00);
    add(-1, 8'h00, 0, LESC_IDX_MDBC, 16'h0001, 8'h00);
    add(-1, 8'h00, -1, LESC_IDX_STFLAG, 16'h00db, 8'h00);
    add(-1, 8'h00, -1, 4'he, 16'h0000, 8'h00);
    repeat (16) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    chk({8'h00, NAK_TX_REASON_O}, 16'h0000);
    rdchk(2'h0, LESC_IDX_LREP, 16'h0000);
    TRIB_SEL_I <= 2'h1;
    foreach (rows[i]) begin
      fire(rows[i].lev, rows[i].sev, 1);
      chk({15'h0000, NAK_TX_REQ_O}, {15'h0000, |rows[i].nak});
      if (rows[i].nak != 8'h00) chk({8'h00, NAK_TX_REASON_O}, {8'h00, rows[i].nak});
      rdchk(2'h1, rows[i].idx, rows[i].exp);
    end
    // station set shared, data link set per tributary
    rdchk(2'h2, LESC_IDX_RSTN, 16'h0004);
    rdchk(2'h2, LESC_IDX_LREP, 16'h0000);
    MODE_I <= LESC_MODE_MP_CTRL;
    fire(22'h0, 8'h40, 1);
    rdchk(2'h1, LESC_IDX_RSTN, 16'h0005);
    rdchk(2'h1, LESC_IDX_STFLAG, 16'h00fb);
    // selection counts refused in full duplex
    MODE_I <= LESC_MODE_FDX_P2P;
    fire(lk(6, 8'h00) | lk(5, 8'h00), 8'h00, 1);
    rdchk(2'h1, LESC_IDX_SELINT, 16'h0001);
    rdchk(2'h1, LESC_IDX_SELTO, 16'h0006);
    ovr(LESC_MODE_MP_TRIB, 1'b1, 1'b1, 1'b0);
    ovr(LESC_MODE_FDX_P2P, 1'b0, 1'b0, 1'b0);
    ovr(LESC_MODE_MP_TRIB, 1'b0, 1'b0, 1'b1);
    chk({8'h00, NAK_TX_REASON_O}, 16'h0009);
    rdchk(2'h1, LESC_IDX_LSTN, 16'h0006);
    rdchk(2'h1, LESC_IDX_STFLAG, 16'h00ff);
    // each kind of attempt alone marks the interval partial
    MODE_I <= LESC_MODE_HDX_P2P;
    TRIB_SEL_I <= 2'h2;
    for (int b = 0; b < 5; b++) begin
      ctl(4'h4, 2'h2);
      fire(lk(b, 8'h00), 8'h00, 1);
      fire(lk(5, 8'h00), 8'h00, 1);
      rdchk(2'h2, LESC_IDX_DLFLAG, 16'h0001);
    end
    // long hold drives every kind of counter into its ceiling
    MODE_I <= LESC_MODE_HDX_P2P;
    TRIB_SEL_I <= 2'h3;
    fire(lk(21, 8'h00) | lk(8, 8'h00) | lk(7, 8'h00) | lk(6, 8'h00), 8'h02, 65540);
    @(posedge CLOCK_I);
    WR_I <= 1'b1;
    ADDR_I <= {2'h3, LESC_IDX_LREP};
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
    rdchk(2'h3, LESC_IDX_LREP, 16'h00ff);
    rdchk(2'h3, LESC_IDX_TXMSG, 16'hffff);
    rdchk(2'h3, LESC_IDX_RXMSG, 16'hffff);
    rdchk(2'h3, LESC_IDX_SELINT, 16'hffff);
    rdchk(2'h3, LESC_IDX_GHBC, 16'h00ff);
    // the four clear paths (read-clear, establish, global read-clear, reset), each only where it belongs
    ctl(4'h2, 2'h3);
    rdchk(2'h3, LESC_IDX_LREP, 16'h0000);
    rdchk(2'h1, LESC_IDX_LREP, 16'h0001);
    ctl(4'h4, 2'h1);
    rdchk(2'h1, LESC_IDX_LREP, 16'h0000);
    rdchk(2'h1, LESC_IDX_DLFLAG, 16'h0000);
    rdchk(2'h1, LESC_IDX_RSTN, 16'h0005);
    ctl(4'h1, 2'h0);
    rdchk(2'h1, LESC_IDX_RSTN, 16'h0000);
    rdchk(2'h1, LESC_IDX_STFLAG, 16'h0000);
    fire(lk(20, 8'h00), 8'h01, 1);
    ctl(4'h8, 2'h0);
    rdchk(2'h1, LESC_IDX_MDBC, 16'h0000);
    rdchk(2'h3, LESC_IDX_RREP, 16'h0000);
    summarize();
  end
endmodule : link_error_statistics_counters_tb
